/* File: line_source.sv */
// graphics source model: separated line sync and a free-running pixel clock
`default_nettype none
module line_source #(
  parameter int LINE  = 48, // line length in mclk cycles
  parameter int WIDTH = 4,  // sync pulse width in mclk cycles
  parameter int HALF  = 3   // half period of the external pixel clock
) (
  input  wire logic mclk,      // system clock
  input  wire logic nrst,      // reset, active low
  output logic      line_sync, // separated line sync, active high
  output logic      alt_clk    // external pixel clock
);
  timeunit 1ns;
  timeprecision 100ps;
  int lc;
  int hc;
  // ------------------------------------------------------------------
  // timing generation
  // ------------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      lc        <= 0;
      hc        <= 0;
      line_sync <= 1'b0;
      alt_clk   <= 1'b0;
    end else begin
      lc        <= (lc == LINE - 1) ? 0 : lc + 1;
      // only the separated line pulse, never composite sync
      line_sync <= (lc < WIDTH);
      hc        <= (hc == HALF - 1) ? 0 : hc + 1;
      if (hc == HALF - 1) alt_clk <= !alt_clk;
    end
  end
endmodule
`default_nettype wire

/* File: sel_edge.sv */
// edge finder with selectable active level
`default_nettype none
module sel_edge (
  input  wire logic mclk,     // system clock
  input  wire logic nrst,     // async reset, active low
  input  wire logic ce,       // clock enable
  input  wire logic sig,      // sampled input
  input  wire logic act_high, // 1: rising is leading edge
  output logic      lead,     // leading edge this cycle
  output logic      trail     // trailing edge this cycle
);
  logic prev_q;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      prev_q <= 1'b0;
    end else if (ce) begin
      prev_q <= sig;
    end
  end

  always_comb begin
    lead  = ce & (act_high ? (sig & ~prev_q) : (~sig & prev_q));
    trail = ce & (act_high ? (~sig & prev_q) : (sig & ~prev_q));
  end
endmodule
`default_nettype wire

/* File: sync_clamp_ctl.sv */
// line sync reference, pixel clock control, clamp gating and sync slicer
//
// Design decisions made here: the Avalon-MM slave port and the register offsets.
`include "sync_ctl_consts.svh"
`default_nettype none
module sync_clamp_ctl (
  input  wire logic        mclk,                  // 40 MHz clock
  input  wire logic        nrst,                  // async reset, low
  input  wire logic        ce,                    // clock enable
  input  wire logic        power_down,            // freezes pixel logic
  input  wire logic [4:0]  avs_address,           // byte address
  input  wire logic        avs_read,              // read request
  input  wire logic        avs_write,             // write request
  input  wire logic [31:0] avs_writedata,         // write data
  output logic      [31:0] avs_readdata,          // read data
  output logic             avs_waitrequest,       // stall
  input  wire logic        line_sync_in,          // line sync
  input  wire logic        pll_hold_in,           // generator hold
  input  wire logic        black_level_gate_in,   // external clamp
  input  wire logic        alt_pixel_clk_in,      // alternate clock
  input  wire logic        sample_clk_invert,     // half-period shift
  input  wire logic        green_sync_slicer_in,  // sliced green sync
  output logic             green_sync_slicer_out, // slicer copy
  output logic             line_ref,              // line start pulse
  output logic             pixel_tick,            // pixel clock pulse
  output logic             sample_strobe,         // sampling pulse
  output logic             clamp_active           // clamp window
);
  import sync_ctl_pkg::*;

  state_t     s_q;
  state_t     s_d;
  logic       run;
  logic       ls_lead;
  logic       ls_trail;
  logic       alt_rise;
  logic       hold_act;
  logic       gate_lvl;
  logic       wrap;
  logic       lock;
  logic       base;
  logic [8:0] tgt_sum;
  logic [7:0] tgt;
  logic       bus_req;

  // ------------------------------------------------------------------
  // edge detection
  // ------------------------------------------------------------------
  sel_edge u_line_edge (
    .mclk     (mclk),
    .nrst     (nrst),
    .ce       (ce),
    .sig      (line_sync_in),
    .act_high (s_q.cfg[`CFG_LSYNC_POL]),
    .lead     (ls_lead),
    .trail    (ls_trail)
  );

  sel_edge u_alt_edge (
    .mclk     (mclk),
    .nrst     (nrst),
    .ce       (ce),
    .sig      (alt_pixel_clk_in),
    .act_high (1'b1),
    .lead     (alt_rise),
    .trail    ()
  );

  // ------------------------------------------------------------------
  // combinational decode
  // ------------------------------------------------------------------
  // comparator path needs no clock, so it lives through power-down
  assign green_sync_slicer_out = green_sync_slicer_in;

  always_comb begin
    run      = ce & ~power_down;
    bus_req  = avs_read | avs_write;
    hold_act = (pll_hold_in == s_q.cfg[`CFG_HOLD_POL]);
    gate_lvl = (black_level_gate_in == s_q.cfg[`CFG_GATE_POL]);
    wrap     = (s_q.div_cnt >= s_q.div - 8'h01);
    lock     = ls_lead & ~hold_act;
    base     = s_q.cfg[`CFG_ALT_CLK] ? alt_rise : (wrap | lock);
    // sampling point: phase step, plus half a period when inverted
    tgt_sum  = {4'h0, s_q.phase}
             + (sample_clk_invert ? {2'h0, s_q.div[7:1]} : 9'h000);
    if (tgt_sum >= {1'b0, s_q.div}) begin
      tgt = 8'(tgt_sum - {1'b0, s_q.div});
    end else begin
      tgt = tgt_sum[7:0];
    end
    avs_waitrequest = bus_req & ~s_q.ack;
    avs_readdata    = s_q.rdata;
    line_ref        = s_q.line_ref;
    pixel_tick      = s_q.pix;
    sample_strobe   = s_q.samp;
    clamp_active    = s_q.clamp;
  end

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    if (ce) begin
      // one wait state: data is prepared, then presented with ack
      s_d.ack = bus_req & ~s_q.ack;
      if (bus_req && !s_q.ack) begin
        case (avs_address)
          `OFS_CFG:    s_d.rdata = {27'h0, s_q.cfg};
          `OFS_DIV:    s_d.rdata = {24'h0, s_q.div};
          `OFS_CLDLY:  s_d.rdata = {24'h0, s_q.cldly};
          `OFS_CLDUR:  s_d.rdata = {24'h0, s_q.cldur};
          `OFS_PHASE:  s_d.rdata = {27'h0, s_q.phase};
          `OFS_STATUS: s_d.rdata = {28'h0, green_sync_slicer_in,
                                    line_sync_in, s_q.clamp, hold_act};
          default:     s_d.rdata = 32'h0;
        endcase
      end
      if (avs_write && s_q.ack) begin
        case (avs_address)
          `OFS_CFG:   s_d.cfg   = avs_writedata[4:0];
          `OFS_DIV: begin
            // below two the wrap test would stall the generator
            if (avs_writedata[7:0] < `DIV_MIN) begin
              s_d.div = `DIV_MIN;
            end else begin
              s_d.div = avs_writedata[7:0];
            end
          end
          `OFS_CLDLY: s_d.cldly = avs_writedata[7:0];
          `OFS_CLDUR: s_d.cldur = avs_writedata[7:0];
          `OFS_PHASE: s_d.phase = avs_writedata[4:0];
          default: ;
        endcase
      end
    end

    if (run) begin
      // generator: leading edge realigns it, hold lets it free-run
      s_d.div_cnt  = (lock | wrap) ? 8'h00 : s_q.div_cnt + 8'h01;
      s_d.line_ref = ls_lead;
      s_d.pix      = base;
      // phase counter restarts on every pixel, either source
      if (base) begin
        s_d.ph_cnt = 8'h00;
      end else if (s_q.ph_cnt != 8'hff) begin
        s_d.ph_cnt = s_q.ph_cnt + 8'h01;
      end
      s_d.samp = (s_q.ph_cnt == tgt);

      // internal clamp window in pixel ticks
      case (s_q.cst)
        CL_IDLE: ;
        CL_DELAY: begin
          if (base) begin
            s_d.ccnt = s_q.ccnt + 8'h01;
            if (s_q.ccnt + 8'h01 >= s_q.cldly) begin
              s_d.cst  = CL_HOLD;
              s_d.ccnt = 8'h00;
            end
          end
        end
        CL_HOLD: begin
          if (base) begin
            s_d.ccnt = s_q.ccnt + 8'h01;
            if (s_q.ccnt + 8'h01 >= s_q.cldur) begin
              s_d.cst = CL_IDLE;
            end
          end
        end
        default: s_d.cst = CL_IDLE;
      endcase
      if (ls_trail) begin
        s_d.ccnt = 8'h00;
        s_d.cst  = (s_q.cldly == 8'h00) ? CL_HOLD : CL_DELAY;
      end
      if (s_q.cfg[`CFG_EXT_GATE]) begin
        s_d.cst   = CL_IDLE;
        s_d.clamp = gate_lvl;
      end else begin
        s_d.clamp = (s_d.cst == CL_HOLD);
      end
    end else if (ce) begin
      s_d.line_ref = 1'b0;
      s_d.pix      = 1'b0;
      s_d.samp     = 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // state register
  // ------------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s_q          <= '0;
      s_q.cfg      <= `CFG_RST;
      s_q.div      <= `DIV_RST;
      s_q.cldly    <= `CLDLY_RST;
      s_q.cldur    <= `CLDUR_RST;
      s_q.phase    <= `PHASE_RST;
      s_q.cst      <= CL_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  a_bus_one_wait: assert property (
    (avs_read || avs_write) && avs_waitrequest && ce
      |=> !avs_waitrequest || !(avs_read || avs_write))
    else $error("bus answer not after one wait state");

  a_lead_edge_only: assert property (
    line_ref && $past(ce)
      |-> $past(line_sync_in) == $past(s_q.cfg[`CFG_LSYNC_POL]))
    else $error("line reference on wrong edge");

  a_lock_realign: assert property (
    run && ls_lead && !hold_act |=> s_q.div_cnt == 8'h00)
    else $error("generator not realigned on line edge");

  a_hold_freerun: assert property (
    run && ls_lead && hold_act && !wrap
      |=> s_q.div_cnt == $past(s_q.div_cnt) + 8'h01)
    else $error("generator tracked sync during hold");

  a_hold_sense: assert property (
    run && ls_lead && (pll_hold_in != s_q.cfg[`CFG_HOLD_POL])
      |=> s_q.div_cnt == 8'h00)
    else $error("hold sense inverted");

  a_ext_gate_on: assert property (
    run && s_q.cfg[`CFG_EXT_GATE]
      |=> clamp_active == $past(gate_lvl))
    else $error("external gate not followed");

  a_int_idle_gate: assert property (
    run && !s_q.cfg[`CFG_EXT_GATE] && s_q.cst == CL_IDLE && !ls_trail
      |=> !clamp_active)
    else $error("clamp without trailing edge");

  a_delay_count: assert property (
    run && !s_q.cfg[`CFG_EXT_GATE] && !ls_trail && s_q.cst == CL_DELAY
      && base && s_q.ccnt + 8'h01 >= s_q.cldly
      |=> clamp_active && s_q.cst == CL_HOLD)
    else $error("clamp delay count wrong");

  a_hold_end: assert property (
    run && !s_q.cfg[`CFG_EXT_GATE] && !ls_trail && s_q.cst == CL_HOLD
      && base && s_q.ccnt + 8'h01 >= s_q.cldur
      |=> !clamp_active && s_q.cst == CL_IDLE)
    else $error("clamp duration count wrong");

  a_hold_stays: assert property (
    run && !s_q.cfg[`CFG_EXT_GATE] && !ls_trail && s_q.cst == CL_HOLD
      && !base |=> clamp_active)
    else $error("clamp window ended without pixel");

  a_power_quiet: assert property (
    ce && power_down |=> !pixel_tick && !sample_strobe && !line_ref)
    else $error("pixel pulses during power-down");

  a_alt_tick: assert property (
    run && s_q.cfg[`CFG_ALT_CLK] && alt_rise |=> pixel_tick ##1 !pixel_tick
      || alt_rise)
    else $error("alternate clock not used");

  a_alt_only: assert property (
    run && s_q.cfg[`CFG_ALT_CLK] && !alt_rise |=> !pixel_tick)
    else $error("generated tick with alternate clock");

  a_sample_point: assert property (
    run && s_q.ph_cnt == tgt |=> sample_strobe)
    else $error("sample strobe missed");

  a_slicer_live: assert property (
    power_down && $changed(green_sync_slicer_in)
      |-> $changed(green_sync_slicer_out))
    else $error("slicer stopped in power-down");

endmodule
`default_nettype wire

/* File: sync_ctl_consts.svh */
// offsets, field positions, reset values and limits of the sync/clamp block
`ifndef SYNC_CTL_CONSTS_SVH
`define SYNC_CTL_CONSTS_SVH

// ------------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------------
`define OFS_CFG       5'h00
`define OFS_DIV       5'h04
`define OFS_CLDLY     5'h08
`define OFS_CLDUR     5'h0c
`define OFS_PHASE     5'h10
`define OFS_STATUS    5'h14

// ------------------------------------------------------------------
// configuration register fields
// ------------------------------------------------------------------
`define CFG_LSYNC_POL 0
`define CFG_HOLD_POL  1
`define CFG_EXT_GATE  2
`define CFG_GATE_POL  3
`define CFG_ALT_CLK   4

// ------------------------------------------------------------------
// status register fields
// ------------------------------------------------------------------
`define ST_HOLD       0
`define ST_CLAMP      1
`define ST_LSYNC      2
`define ST_SLICER     3

// ------------------------------------------------------------------
// reset values and limits
// ------------------------------------------------------------------
`define CFG_RST       5'h02
`define DIV_RST       8'h04
`define DIV_MIN       8'h02
`define CLDLY_RST     8'h04
`define CLDUR_RST     8'h08
`define PHASE_RST     5'h00

`endif

/* File: sync_ctl_pkg.sv */
// types shared by the sync, clock and clamp control block
`default_nettype none
package sync_ctl_pkg;

  typedef enum logic [1:0] {
    CL_IDLE,
    CL_DELAY,
    CL_HOLD
  } clamp_st_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
    logic [4:0]  cfg;
    logic [7:0]  div;
    logic [7:0]  cldly;
    logic [7:0]  cldur;
    logic [4:0]  phase;
    logic [7:0]  div_cnt;
    logic [7:0]  ph_cnt;
    clamp_st_t   cst;
    logic [7:0]  ccnt;
    logic        clamp;
    logic        line_ref;
    logic        pix;
    logic        samp;
  } state_t;

endpackage
`default_nettype wire

/* File: tb.sv */
// self-checking bench of the sync, clock and clamp control block
`include "sync_ctl_consts.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        mclk = 0, nrst = 0, power_down = 0, man = 0, use_src = 0;
  logic        avs_read = 0, avs_write = 0, hold = 0, gate = 0, inv = 0;
  logic        green = 0, wreq, slice_out, lref, tick, strobe, clamp;
  logic        src_sync, src_alt;
  logic        ce_in = 1;
  logic [4:0]  avs_address = 0;
  logic [31:0] avs_writedata = 0, rdata, rd, w;
  wire logic   lsync = use_src ? src_sync : man;
  int          n_errors = 0, num_checks = 0, cyc = 0, seed = 30;
  int          k, k2, d, ph;
  logic [4:0]  ofs [5] = '{`OFS_CFG, `OFS_DIV, `OFS_CLDLY, `OFS_CLDUR,
                           `OFS_PHASE};
  logic [31:0] rv [5] = '{`CFG_RST, `DIV_RST, `CLDLY_RST, `CLDUR_RST,
                          `PHASE_RST};

  always #12.5 mclk = ~mclk;

  sync_clamp_ctl uut (.mclk(mclk), .nrst(nrst), .ce(ce_in),
    .power_down(power_down), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(rdata),
    .avs_waitrequest(wreq), .line_sync_in(lsync), .pll_hold_in(hold),
    .black_level_gate_in(gate), .alt_pixel_clk_in(src_alt),
    .sample_clk_invert(inv), .green_sync_slicer_in(green),
    .green_sync_slicer_out(slice_out), .line_ref(lref),
    .pixel_tick(tick), .sample_strobe(strobe), .clamp_active(clamp));
  line_source src (.mclk(mclk), .nrst(nrst), .line_sync(src_sync),
    .alt_clk(src_alt));

  // ------------------------------------------------------------------
  // checking and bus tasks
  // ------------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic results();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // request held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [31:0] dat);
    int t;
    t = 0;
    avs_address   <= a;
    avs_writedata <= dat;
    avs_write     <= wr;
    avs_read      <= !wr;
    do begin
      @(posedge mclk);
      t++;
    end while (wreq !== 1'b0 && t < 40);
    rd = rdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (t == 40) chk("bus answer", 0, 1);
    @(posedge mclk);
  endtask

  task automatic count_ref(input int n);
    k  = 0;
    k2 = 0;
    repeat (n) begin
      @(posedge mclk);
      k  += int'(lref === 1'b1);
      k2 += int'(lref === 1'b1 && tick === 1'b1);
    end
  endtask

  task automatic gaps(input int per, input int n);
    int c, last, bad;
    c    = 0;
    last = -1;
    bad  = 0;
    repeat (n) begin
      @(posedge mclk);
      c++;
      if (tick === 1'b1) begin
        if (last >= 0 && c - last != per) bad++;
        last = c;
      end
    end
    chk("tick spacing", 0, (last < 0) ? 1 : bad);
  endtask

  task automatic runs(input int len, input int n);
    int r, bad, seen;
    logic arm;
    r    = 0;
    bad  = 0;
    seen = 0;
    arm  = 1'b0;
    repeat (n) begin
      gate <= 1'($random(seed));
      @(posedge mclk);
      if (clamp === 1'b1) r++;
      else begin
        // a run already under way at the start is only partly seen
        if (arm && r != 0) seen++;
        if (arm && r != 0 && r != len) bad++;
        r   = 0;
        arm = 1'b1;
      end
    end
    chk("clamp length", 0, (seen == 0) ? 1 : bad);
  endtask

  // samples near a phase change may be bad, so settle first
  task automatic sdelay(output int dl);
    int t;
    t = 0;
    repeat (20) @(posedge mclk);
    while (tick !== 1'b1 && t < 40) begin
      @(posedge mclk);
      t++;
    end
    dl = 0;
    do begin
      @(posedge mclk);
      dl++;
    end while (strobe !== 1'b1 && dl < 40);
  endtask

  function automatic int exp_d(int p, int iv, int dv);
    return ((p + (iv != 0 ? dv / 2 : 0)) % dv) + 1;
  endfunction

  function automatic logic [31:0] exp_reg(int i, logic [31:0] v);
    logic [31:0] m;
    m = v & ((i == 0 || i == 4) ? 32'h1f : 32'hff);
    if (i == 1 && m < `DIV_MIN) m = `DIV_MIN;
    return m;
  endfunction

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      results();
    end
  end

  // ------------------------------------------------------------------
  // test sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (16) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    for (int i = 0; i < 5; i++) begin
      bus(0, ofs[i], 0);
      chk("reset value", rv[i], rd);
    end
    for (int i = 0; i < 5; i++) begin
      w = $random(seed);
      if (i == 1 && w[0]) w = 32'h1;
      bus(1, ofs[i], w);
      bus(0, ofs[i], 0);
      chk("readback", exp_reg(i, w), rd);
    end
    bus(0, 5'h18, 0);
    chk("unmapped", 0, rd);
    bus(1, `OFS_DIV, 4);
    bus(1, `OFS_PHASE, 0);
    for (int p = 0; p < 2; p++) begin
      bus(1, `OFS_CFG, 32'h2 | p);
      repeat (4) begin
        man <= !man;
        count_ref(6);
        chk("line ref", 32'(man === p[0]), k);
        chk("realign", k, k2);
      end
    end
    hold <= 1'b1;
    repeat (4) begin
      man <= !man;
      gaps(4, 20);
    end
    hold <= 1'b0;
    bus(0, `OFS_STATUS, 0);
    chk("hold idle", 0, 32'(rd[`ST_HOLD]));
    bus(1, `OFS_CFG, 0);
    bus(0, `OFS_STATUS, 0);
    chk("hold low", 1, 32'(rd[`ST_HOLD]));
    bus(1, `OFS_DIV, 6);
    for (int m = 0; m < 2; m++) begin
      bus(1, `OFS_CFG, 32'h2 | (m << `CFG_ALT_CLK));
      gaps(6, 60);
      for (int iv = 0; iv < 2; iv++) begin
        ph = {$random(seed)} % 6;
        bus(1, `OFS_PHASE, ph);
        inv <= iv[0]; // one frame per phase
        sdelay(d);
        chk("strobe delay", exp_d(ph, iv, 6), d);
      end
    end
    bus(1, `OFS_DIV, 4);
    bus(1, `OFS_CLDLY, 2);
    bus(1, `OFS_CLDUR, 3);
    bus(1, `OFS_CFG, 32'h3);
    use_src <= 1'b1;
    // one source trailing edge restarts any window of the old counts
    repeat (56) @(posedge mclk);
    runs(12, 200);
    for (int i = 0; i < 8; i++) begin
      bus(1, `OFS_CFG, 32'h7 | (i[0] << `CFG_GATE_POL));
      // gate only in the back porch after the sync pulse
      while (src_sync !== 1'b1) @(posedge mclk);
      while (src_sync !== 1'b0) @(posedge mclk);
      gate <= 1'($random(seed));
      repeat (3) @(posedge mclk);
      chk("ext clamp", 32'(gate === i[0]), 32'(clamp));
      gate <= !i[0];
    end
    repeat (3) @(posedge mclk);
    ce_in <= 1'b0;
    gate  <= 1'b1;
    repeat (3) @(posedge mclk);
    chk("enable freeze", 0, 32'(clamp));
    ce_in <= 1'b1;
    for (int i = 0; i < 32; i++) begin
      power_down <= (i >= 16);
      green      <= 1'($random(seed));
      @(posedge mclk);
      chk("slicer copy", 32'(green), 32'(slice_out));
      if (i > 20) chk("frozen tick", 0, 32'(tick));
    end
    results();
  end
endmodule
`default_nettype wire
